// File: hdl/async_serial_receiver.sv
// receive half of the asynchronous serial interface, wishbone register slave
// assumes the pin is synchronous to REF_CLK and the master follows classic cycles
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "serial_rx_defs.svh"

module async_serial_receiver #(
  parameter int DATA_W = 9
) (
  // clock and reset
  input  wire logic                     REF_CLK,
  input  wire logic                     RST_N,
  // register bus
  input  wire serial_rx_pkg::wb_req_s   WB_REQ,
  output serial_rx_pkg::wb_rsp_s        WB_RSP,
  // serial line and request
  input  wire logic                     SERIAL_RX_PIN,
  input  wire logic                     CPU_IRQ_MASK,
  output logic                          IRQ_REQ
);
  import serial_rx_pkg::*;

  // rx_state_e is the receive sequencer
  rx_state_e   state_r;
  logic [7:0]  status_r;
  logic [6:0]  ctrl_one_r;
  logic        rx_ninth_bit_r;
  logic [7:0]  ctrl_two_r;
  logic [15:0] baud_r;
  logic [8:0]  rx_buffer;
  logic [8:0]  shift_r;
  logic [3:0]  bit_cnt_r;
  logic [3:0]  samp_cnt_r;
  logic [2:0]  mid_r;
  logic [2:0]  pre_hist_r;
  logic        noise_r;
  logic        hidden_noise_r;
  logic [7:0]  idle_cnt_r;
  logic        stat_seen_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [10:0] tick_cnt_r;
  logic        tick;

  logic        bus_req;
  logic        wr_ctrl_two;
  logic        rd_data;
  logic        frame_end;
  logic        idle_hit;
  logic [7:0]  frame_samples;
  logic        word_len;
  logic [3:0]  payload_bits;
  logic        bit_val;
  logic        bit_noise;
  logic        par_err;
  logic        mute;
  logic        wake_idle;
  logic        wake_addr;
  logic        msb_bit;
  logic [10:0] tick_limit;

  // rl13 decode: prescale factor from its two-bit field
  function automatic logic [3:0] prescale_factor(input logic [1:0] fld);
    case (fld)
      2'h0:    prescale_factor = 4'h1;
      2'h1:    prescale_factor = 4'h3;
      2'h2:    prescale_factor = 4'h4;
      default: prescale_factor = 4'hd;
    endcase
  endfunction

  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  // RL12 sample rate
  // rx divide factor as a power of two times the prescale, one tick per sample
  // RL13 field decode
  assign tick_limit = 11'((11'(prescale_factor(baud_r[`BD_PRE_LSB +: 2])) << baud_r[`BD_RXDIV_LSB +: 3]) - 11'h1);

  // RL24 sample tick
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_r <= 11'h0;
    end else if (tick || !ctrl_two_r[`C2_RX_EN]) begin
      tick_cnt_r <= 11'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 11'h1;
    end
  end
  assign tick = ctrl_two_r[`C2_RX_EN] && (tick_cnt_r == tick_limit);

  assign word_len     = ctrl_one_r[`C1_WORD_LEN];
  // RL19 payload length
  assign payload_bits = word_len ? 4'h9 : 4'h8;
  // RL7 majority and noise
  assign bit_val      = majority3(mid_r);
  assign bit_noise    = !(mid_r == 3'h0 || mid_r == 3'h7);
  assign mute         = ctrl_two_r[`C2_MUTE];
  assign bus_req      = WB_REQ.cyc && WB_REQ.stb && !ack_r;
  assign wr_ctrl_two  = bus_req && WB_REQ.we && WB_REQ.adr == `ADR_CTRL_TWO && WB_REQ.sel[0];
  assign rd_data      = bus_req && !WB_REQ.we && WB_REQ.adr == `ADR_DATA;

  // frame end: stop-bit sample 10 taken
  assign frame_end = tick && state_r == RX_STOP && samp_cnt_r == `SAMPLE_MID_C;
  // RL6 an idle frame spans start, payload and stop, all high
  assign frame_samples = {payload_bits + 4'h2, 4'h0};
  assign msb_bit   = word_len ? shift_r[8] : shift_r[7];
  // RL21 the far transmitter puts parity in the msb slot; it stays in the buffer
  // RL20 parity over low 7 or 8 bits plus parity bit
  assign par_err   = ctrl_one_r[`C1_PARITY_EN] &&
                     ((word_len ? ^shift_r[8:0] : ^shift_r[7:0]) != ctrl_one_r[`C1_PARITY_ODD]);
  // RL16 idle wake
  assign wake_idle = idle_hit && mute && !ctrl_one_r[`C1_WAKE_ADDR];
  // RL17 address mark wake, msb not parity
  assign wake_addr = frame_end && mute && ctrl_one_r[`C1_WAKE_ADDR] && msb_bit;

  // receive sequencer with sampling history
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r    <= RX_HUNT;
      samp_cnt_r <= 4'h0;
      bit_cnt_r  <= 4'h0;
      mid_r      <= 3'h0;
      pre_hist_r <= 3'h0;
      shift_r    <= 9'h0;
      noise_r    <= 1'b0;
    end else if (!ctrl_two_r[`C2_RX_EN]) begin
      state_r    <= RX_HUNT;
      pre_hist_r <= 3'h0;
    end else if (tick) begin
      case (state_r)
        // RL1 hunt for start edge
        RX_HUNT: begin
          pre_hist_r <= {pre_hist_r[1:0], SERIAL_RX_PIN};
          // a line that stays low is no edge: a high sample must come first
          if (!SERIAL_RX_PIN && pre_hist_r[0]) begin
            state_r    <= RX_START;
            samp_cnt_r <= 4'h1;
            // RL8 three ones before the edge
            noise_r    <= (pre_hist_r != 3'h7);
            bit_cnt_r  <= 4'h0;
          end
        end
        RX_START: begin
          samp_cnt_r <= samp_cnt_r + 4'h1;
          // RL8 samples 3, 5, 7 after the edge
          if ((samp_cnt_r == 4'h2 || samp_cnt_r == 4'h4 || samp_cnt_r == 4'h6) && SERIAL_RX_PIN) begin
            noise_r <= 1'b1;
          end
          if (samp_cnt_r >= `SAMPLE_MID_A && samp_cnt_r <= `SAMPLE_MID_C) begin
            mid_r <= {SERIAL_RX_PIN, mid_r[2:1]};
          end
          // RL10 false start discards frame
          if (samp_cnt_r == `SAMPLE_MID_C + 4'h1 && mid_r != 3'h0) begin
            state_r <= RX_HUNT;
            pre_hist_r <= 3'h0;
          end else if (samp_cnt_r == `SAMPLES_PER_BIT) begin
            state_r    <= RX_DATA;
            samp_cnt_r <= 4'h0;
          end
        end
        RX_DATA: begin
          samp_cnt_r <= samp_cnt_r + 4'h1;
          if (samp_cnt_r >= `SAMPLE_MID_A && samp_cnt_r <= `SAMPLE_MID_C) begin
            mid_r <= {SERIAL_RX_PIN, mid_r[2:1]};
          end
          if (samp_cnt_r == `SAMPLE_MID_C + 4'h1) begin
            // RL1 lsb first, msb lands in top
            shift_r    <= word_len ? {bit_val, shift_r[8:1]} : {1'b0, bit_val, shift_r[7:1]};
            noise_r    <= noise_r | bit_noise;
          end
          if (samp_cnt_r == `SAMPLES_PER_BIT) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == payload_bits - 4'h1) begin
              state_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          samp_cnt_r <= samp_cnt_r + 4'h1;
          if (samp_cnt_r >= `SAMPLE_MID_A && samp_cnt_r < `SAMPLE_MID_C) begin
            mid_r <= {SERIAL_RX_PIN, mid_r[2:1]};
          end
          if (samp_cnt_r == `SAMPLE_MID_C) begin
            state_r    <= RX_HUNT;
            // a low stop bit must not pass for the ones ahead of the next edge
            pre_hist_r <= {3{SERIAL_RX_PIN}};
          end
        end
        default: state_r <= RX_HUNT;
      endcase
    end
  end

  // stop-bit value uses the third sample directly
  logic stop_val;
  logic stop_noise;
  assign stop_val   = majority3({SERIAL_RX_PIN, mid_r[2:1]});
  assign stop_noise = !(mid_r[2:1] == {2{SERIAL_RX_PIN}});

  // RL10 hidden noise carried to the next valid frame
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hidden_noise_r <= 1'b0;
    end else if (tick && state_r == RX_START && samp_cnt_r == `SAMPLE_MID_C + 4'h1 && mid_r != 3'h0) begin
      hidden_noise_r <= 1'b1;
    end else if (frame_end && !mute) begin
      hidden_noise_r <= 1'b0;
    end
  end

  // RL6 idle line: a whole frame of ones while hunting; fires once, then rests
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      idle_cnt_r <= 8'h0;
    end else if (!ctrl_two_r[`C2_RX_EN] || state_r != RX_HUNT) begin
      idle_cnt_r <= 8'h0;
    end else if (tick) begin
      if (!SERIAL_RX_PIN) begin
        idle_cnt_r <= 8'h0;
      end else if (idle_cnt_r != frame_samples) begin
        idle_cnt_r <= idle_cnt_r + 8'h1;
      end
    end
  end
  assign idle_hit = tick && state_r == RX_HUNT && SERIAL_RX_PIN && idle_cnt_r == frame_samples - 8'h1;

  // status flags, buffer and ninth bit
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_r  <= `RST_STATUS;
      rx_buffer <= 9'h0;
      rx_ninth_bit_r <= 1'b0;
    end else begin
      // RL3 status access then data read clears; a new frame end wins over the clear
      if (rd_data && stat_seen_r) begin
        status_r[5:0] <= 6'h0;
      end
      // RL15 muted receiver sets no status
      if (frame_end && !mute) begin
        if (status_r[`ST_RX_FULL] && !(rd_data && stat_seen_r)) begin
          // RL4 overrun keeps old buffer
          status_r[`ST_OVERRUN] <= 1'b1;
        end else begin
          // RL2 transfer and set full
          status_r[`ST_RX_FULL] <= 1'b1;
          rx_buffer             <= shift_r;
          // RL23 ninth bit kept apart
          rx_ninth_bit_r        <= shift_r[8];
          // RL9 noise rises with full flag
          status_r[`ST_NOISE]   <= noise_r | hidden_noise_r | stop_noise;
          // RL11 missing stop or RL5 break: framing error
          status_r[`ST_FRAMING] <= !stop_val;
          // RL22 parity mismatch
          status_r[`ST_PARITY]  <= par_err;
        end
      end else if (idle_hit && !mute) begin
        // RL6 idle line handled like a character, plus its own flag
        status_r[`ST_RX_FULL] <= 1'b1;
        status_r[`ST_IDLE]    <= 1'b1;
      end else if (wake_addr) begin
        // RL17 address word received normally
        status_r[`ST_RX_FULL] <= 1'b1;
        rx_buffer             <= shift_r;
        rx_ninth_bit_r        <= shift_r[8];
      end
    end
  end

  // RL3 status access arms the clearing sequence
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_seen_r <= 1'b0;
    end else if (bus_req && WB_REQ.adr == `ADR_STATUS) begin
      stat_seen_r <= 1'b1;
    end else if (rd_data) begin
      stat_seen_r <= 1'b0;
    end
  end

  // control registers; hardware clears the mute bit on wake
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_one_r[6:0] <= 7'h0;
      ctrl_two_r      <= `RST_CTRL;
      baud_r          <= `RST_BAUD;
    end else begin
      if (bus_req && WB_REQ.we && WB_REQ.adr == `ADR_CTRL_ONE && WB_REQ.sel[0]) begin
        ctrl_one_r[6:0] <= WB_REQ.dat[6:0];
      end
      if (wr_ctrl_two) begin
        ctrl_two_r <= WB_REQ.dat[7:0];
      end
      // RL16 RL17 wake clears mute
      if (wake_idle || wake_addr) begin
        ctrl_two_r[`C2_MUTE] <= 1'b0;
      end
      // RL14 software keeps these stable while enabled
      if (bus_req && WB_REQ.we && WB_REQ.adr == `ADR_BAUD) begin
        if (WB_REQ.sel[0]) baud_r[7:0]  <= WB_REQ.dat[7:0];
        if (WB_REQ.sel[1]) baud_r[15:8] <= WB_REQ.dat[15:8];
      end
    end
  end

  // wishbone answer, one cycle after the request
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !WB_REQ.we) begin
        case (WB_REQ.adr)
          `ADR_STATUS:   rdat_r <= {24'h0, status_r};
          `ADR_DATA:     rdat_r <= {23'h0, rx_buffer};
          `ADR_CTRL_ONE: rdat_r <= {24'h0, rx_ninth_bit_r, ctrl_one_r};
          `ADR_CTRL_TWO: rdat_r <= {24'h0, ctrl_two_r};
          `ADR_BAUD:     rdat_r <= {16'h0, baud_r};
          default:       rdat_r <= 32'h0;
        endcase
      end
    end
  end
  assign WB_RSP.ack = ack_r;
  assign WB_RSP.dat = rdat_r;

  // RL2 RL4 RL6 RL22 interrupt request, RL15 blocked while muted
  assign IRQ_REQ = !CPU_IRQ_MASK && !mute &&
                   ((ctrl_two_r[`C2_RX_IE] && (status_r[`ST_RX_FULL] || status_r[`ST_OVERRUN])) ||
                    (ctrl_two_r[`C2_IDLE_IE] && status_r[`ST_IDLE]) ||
                    (ctrl_one_r[`C1_PARITY_IE] && status_r[`ST_PARITY]));

  // RL3 full flag drops only after status then data read
  clear_seq_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RL3
    $fell(status_r[`ST_RX_FULL]) |-> $past(rd_data && stat_seen_r))
    else $error("full flag fell without clear sequence");

  // RL4 buffer stable on overrun
  overrun_keep_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RL4
    $rose(status_r[`ST_OVERRUN]) |-> $stable(rx_buffer))
    else $error("buffer changed on overrun");

  // RL15 mute blocks reception status
  mute_block_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RL15
    mute && !wake_addr |=> !$rose(status_r[`ST_RX_FULL]) && !$rose(status_r[`ST_OVERRUN]))
    else $error("status set while muted");

  // RL9 noise rises only with full
  noise_with_full_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RL9
    $rose(status_r[`ST_NOISE]) |-> $rose(status_r[`ST_RX_FULL]))
    else $error("noise rose alone");

  // RL16 idle wake leaves idle flag clear
  idle_wake_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RL16
    wake_idle |=> !mute && !$rose(status_r[`ST_IDLE]))
    else $error("idle wake wrong");

  // RL17 address wake sets full
  addr_wake_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RL17
    wake_addr |=> status_r[`ST_RX_FULL] && !mute)
    else $error("address wake did not receive word");

  // RL24 sample tick spacing
  tick_space_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RL24
    tick && tick_limit == 11'h0 && $stable(baud_r) && !wr_ctrl_two |=> tick)
    else $error("tick spacing wrong");

  // RL2 full flag sets only at frame end or on an idle frame
  full_cause_a: assert property (@(posedge REF_CLK) disable iff (!RST_N) // RL2
    $rose(status_r[`ST_RX_FULL]) |-> $past(frame_end || idle_hit))
    else $error("full flag set without frame");

endmodule

// File: hdl/serial_rx_defs.svh
// constants for the serial receiver: register offsets, field positions, reset values
// assumes a 32-bit classic wishbone slave, byte addressing, one register per word
// Function
// RL1: setting receiver enable starts start-bit hunt; data bits arrive lsb first.
// RL2: at frame end move shift data to buffer, set full flag, request interrupt.
// RL3: status access then data read clears full, overrun, noise, framing flags.
// RL4: frame ending while full sets overrun, keeps old buffer, may interrupt.
// RL5: a break character is handled exactly like a framing error.
// RL6: idle frame acts as a received character, sets idle flag, may interrupt.
// RL7: sixteen samples per bit; majority of 8,9,10 gives value; disagreement flags noise.
// RL8: start bit noisy without three ones before edge, or ones at 3,5,7,8-10.
// RL9: noisy frame still stored; noise rises with full flag, no own interrupt.
// RL10: start bit middle samples not all zero: discard frame, keep hidden noise.
// RL11: missing stop bit or break sets framing error; data still stored, no interrupt.
// RL12: rx baud is clock over sixteen times prescale times own divider.
// RL13: two-bit prescale picks 1,3,4,13; three-bit dividers pick powers 1..128.
// RL14: software keeps baud settings unchanged while transmitter or receiver enabled.
// RL15: while mute bit set no receive flag is set and receive interrupts blocked.
// RL16: idle-line wake method: idle frame clears mute bit, idle flag stays clear.
// RL17: address-mark method: word msb one clears mute, word received normally.
// RL18: software does not write control two while muted.
// RL19: frame is start, 8 or 9 payload bits (data or data plus parity), stop.
// RL20: parity bit makes ones count of low 7 or 8 bits plus parity even/odd.
// RL21: transmitter replaces data msb with parity when parity is enabled.
// RL22: receiver checks parity; mismatch sets parity error, interrupt if enabled.
// RL23: word length bit picks eight or nine data bits; ninth bit stored separately.
// RL24: sample tick at sixteen times baud; sample positions counted from start edge.
`ifndef SERIAL_RX_DEFS_SVH
`define SERIAL_RX_DEFS_SVH

`define ADR_STATUS     8'h00
`define ADR_DATA       8'h04
`define ADR_CTRL_ONE   8'h08
`define ADR_CTRL_TWO   8'h0c
`define ADR_BAUD       8'h10

// status register bits
`define ST_TX_EMPTY    7
`define ST_TX_DONE     6
`define ST_RX_FULL     5
`define ST_IDLE        4
`define ST_OVERRUN     3
`define ST_NOISE       2
`define ST_FRAMING     1
`define ST_PARITY      0

// control one bits
`define C1_NINTH_RX    7
`define C1_NINTH_TX    6
`define C1_DISABLE     5
`define C1_WORD_LEN    4
`define C1_WAKE_ADDR   3
`define C1_PARITY_EN   2
`define C1_PARITY_ODD  1
`define C1_PARITY_IE   0

// control two bits
`define C2_TX_IE       7
`define C2_TXDONE_IE   6
`define C2_RX_IE       5
`define C2_IDLE_IE     4
`define C2_TX_EN       3
`define C2_RX_EN       2
`define C2_MUTE        1
`define C2_BREAK       0

// baud register fields
`define BD_PRE_LSB     4
`define BD_TXDIV_LSB   0
`define BD_RXDIV_LSB   8

`define RST_STATUS     8'hc0
`define RST_CTRL       8'h00
`define RST_BAUD       16'h0000

`define SAMPLES_PER_BIT 4'hf
`define SAMPLE_MID_A   4'h7
`define SAMPLE_MID_B   4'h8
`define SAMPLE_MID_C   4'h9

`endif

// File: hdl/serial_rx_pkg.sv
// types shared by the serial receiver
// assumes serial_rx_defs.svh carries the numbers
package serial_rx_pkg;

  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP} rx_state_e;

  // wishbone request bundle from the bus master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  // wishbone answer bundle back to the master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

endpackage

// File: verification/serial_line_sender.sv
// far-side model: an external transmitter of nrz frames
// assumes pin is sampled on REF_CLK; line idles high between frames
`timescale 1ns/100ps

module serial_line_sender (
  // clock
  input  wire logic clk,
  // serial line toward the receiver
  output logic      line
);
  initial line = 1'b1;

  // one level for bl clocks, changed just after an edge
  task automatic hold(input logic b, input int bl);
    line <= b;
    repeat (bl) @(posedge clk);
  endtask

  task automatic send(input logic [8:0] v, input int n, input logic stp, input int bl);
    // a full bit of ones ahead of the start edge
    hold(1'b1, bl);
    // one start bit, payload, one stop bit
    hold(1'b0, bl);
    for (int i = 0; i < n; i++) hold(v[i], bl);
    hold(stp, bl);
    // ones ahead of the next start edge
    hold(1'b1, bl);
  endtask

  // too short for a start bit: middle samples see ones
  task automatic pulse(input int w);
    @(posedge clk);
    hold(1'b0, w);
    hold(1'b1, 32);
  endtask
endmodule

// File: verification/tb.sv
// self-checking bench for the serial receiver
// assumes one 100 MHz clock, a classic wishbone master and the line model
`timescale 1ns/100ps
`include "serial_rx_defs.svh"

module tb;
  import serial_rx_pkg::*;
  localparam logic [7:0] EN = 8'h1 << `C2_RX_EN;
  localparam logic [7:0] FULL = `RST_STATUS | (8'h1 << `ST_RX_FULL);
  logic        clk;
  logic        rst_n;
  logic        mask;
  wire logic   pin;
  wb_req_s     req;
  wb_rsp_s     rsp;
  logic        irq;
  logic [31:0] q;
  logic [7:0]  st;
  logic [31:0] dt;
  int          n_mismatch;
  int          checked;
  int          cycles;
  int          pr [4] = '{1, 3, 4, 13};

  async_serial_receiver #(.DATA_W(9)) DUT (.REF_CLK(clk), .RST_N(rst_n), .WB_REQ(req), .WB_RSP(rsp),
    .SERIAL_RX_PIN(pin), .CPU_IRQ_MASK(mask), .IRQ_REQ(irq));
  serial_line_sender PEER (.clk(clk), .line(pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // request held until ack is sampled high, then released
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    q = rsp.dat;
    req <= '0;
    if (n >= 50) check("ack", 0, 1);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask

  // baud written only with the receiver off
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [15:0] bd);
    wb(1'b1, `ADR_CTRL_TWO, 32'h0);
    wb(1'b1, `ADR_BAUD, {16'h0, bd});
    wb(1'b1, `ADR_CTRL_ONE, {24'h0, c1});
    wb(1'b1, `ADR_CTRL_TWO, {24'h0, c2});
  endtask

  // status access then data read
  task automatic drain;
    rd(`ADR_STATUS);
    st = q[7:0];
    rd(`ADR_DATA);
    dt = q;
  endtask

  task automatic t_reset;
    rd(`ADR_STATUS); check("status", q, {24'h0, `RST_STATUS});
    rd(`ADR_CTRL_ONE); check("ctrl1", q, {24'h0, `RST_CTRL});
    rd(`ADR_CTRL_TWO); check("ctrl2", q, {24'h0, `RST_CTRL});
    rd(`ADR_BAUD); check("baud", q, {16'h0, `RST_BAUD});
    rd(8'h20); check("unmapped", q, 32'h0);
  endtask

  task automatic t_basic;
    PEER.send(9'h0a5, 8, 1'b1, 16);
    rd(`ADR_STATUS); check("off", q[7:0], `RST_STATUS);
    cfg(8'h0, EN | (8'h1 << `C2_RX_IE), 16'h0);
    PEER.send(9'h0a5, 8, 1'b1, 16);
    check("irq", irq, 1'b1);
    mask <= 1'b1;
    repeat (2) @(posedge clk);
    check("irq masked", irq, 1'b0);
    mask <= 1'b0;
    PEER.send(9'h011, 8, 1'b1, 16);
    drain;
    check("ovr st", st, FULL | (8'h1 << `ST_OVERRUN));
    check("ovr data", dt, 32'h0a5);
    rd(`ADR_STATUS); check("cleared", q[7:0], `RST_STATUS);
  endtask

  task automatic t_framing;
    PEER.send(9'h03c, 8, 1'b0, 16);
    drain;
    check("fe st", st, FULL | (8'h1 << `ST_FRAMING));
    check("fe data", dt, 32'h03c);
    check("fe irq", irq, 1'b0);
    PEER.send(9'h000, 8, 1'b0, 16);
    drain;
    check("brk st", st, FULL | (8'h1 << `ST_FRAMING));
  endtask

  task automatic t_noise;
    PEER.pulse(8);
    rd(`ADR_STATUS); check("false start", q[7:0], `RST_STATUS);
    PEER.send(9'h066, 8, 1'b1, 16);
    drain;
    check("nf st", st, FULL | (8'h1 << `ST_NOISE));
    check("nf data", dt, 32'h066);
  endtask

  task automatic t_parity;
    logic [7:0] b;
    for (int o = 0; o < 2; o++) begin
      for (int k = 0; k < 2; k++) begin
        b = k ? 8'hb5 : 8'h35;
        cfg(8'((8'h1 << `C1_PARITY_EN) | (8'h1 << `C1_PARITY_IE) | (o << `C1_PARITY_ODD)), EN, 16'h0);
        PEER.send({1'b0, b}, 8, 1'b1, 16);
        check("pe irq", irq, (^b) ^ o[0]);
        drain;
        check("pe flag", st[`ST_PARITY], (^b) ^ o[0]);
        check("pe data", dt[6:0], b[6:0]);
      end
    end
  endtask

  task automatic t_ninth;
    cfg(8'h1 << `C1_WORD_LEN, EN, 16'h0);
    PEER.send(9'h155, 9, 1'b1, 16);
    rd(`ADR_CTRL_ONE); check("ninth", q[`C1_NINTH_RX], 1'b1);
    drain;
    check("nine data", dt, 32'h155);
  endtask

  task automatic t_idle;
    cfg(8'h0, EN | (8'h1 << `C2_IDLE_IE), 16'h0);
    PEER.send(9'h00f, 8, 1'b1, 16);
    drain;
    repeat (192) @(posedge clk);
    check("idle irq", irq, 1'b1);
    drain;
    check("idle flag", st[`ST_IDLE], 1'b1);
  endtask

  // no control two write while muted
  task automatic t_mute;
    cfg(8'h1 << `C1_WAKE_ADDR, EN | (8'h1 << `C2_RX_IE) | (8'h1 << `C2_MUTE), 16'h0);
    PEER.send(9'h012, 8, 1'b1, 16);
    rd(`ADR_STATUS); check("muted st", q[7:0], `RST_STATUS);
    check("muted irq", irq, 1'b0);
    PEER.send(9'h085, 8, 1'b1, 16);
    rd(`ADR_CTRL_TWO); check("addr wake", q[`C2_MUTE], 1'b0);
    drain;
    check("addr st", st, FULL);
    check("addr data", dt, 32'h085);
    cfg(8'h0, EN | (8'h1 << `C2_MUTE), 16'h0);
    PEER.send(9'h012, 8, 1'b1, 16);
    repeat (192) @(posedge clk);
    rd(`ADR_CTRL_TWO); check("idle wake", q[`C2_MUTE], 1'b0);
    rd(`ADR_STATUS); check("idle wake st", q[7:0], `RST_STATUS);
  endtask

  task automatic t_baud;
    for (int p = 0; p < 5; p++) begin
      cfg(8'h0, EN, p < 4 ? 16'(p << `BD_PRE_LSB) : 16'h0310);
      PEER.send(9'h05a, 8, 1'b1, p < 4 ? 16 * pr[p] : 384);
      drain;
      check("baud data", dt, 32'h05a);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      conclude;
    end
  end

  initial begin
    rst_n = 1'b0;
    mask = 1'b0;
    req = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_basic;
    t_framing;
    t_noise;
    t_parity;
    t_ninth;
    t_idle;
    t_mute;
    t_baud;
    conclude;
  end
endmodule
